//--- sfcw_bias_ctr.v
/*
 * focus bias counter: moves by a selectable step once per sampling strobe.
 * assumes the strobe is one core clock wide and ce gates all state.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfcw_consts.vh"
module sfcw_bias_ctr #(
  parameter W = 10
) (
  input  wire         core_clk_in,
  input  wire         sys_rst_in,
  input  wire         ce_in,
  input  wire         tick_in,
  input  wire         on_in,
  input  wire         ss_in,
  input  wire         up_in,
  input  wire [1:0]   step_sel_in,
  output reg  [W-1:0] count_out
);
  wire [W:0] step;
  wire [W:0] sum_up;
  wire [W:0] sum_dn;
  wire [W:0] max_v;

  // [R01] step 1/2/4/8
  assign step   = {{W{1'b0}}, 1'b1} << step_sel_in;
  assign sum_up = {1'b0, count_out} + step;
  assign sum_dn = {1'b0, count_out} - step;
  assign max_v  = {1'b0, {W{1'b1}}};

  // [R02] one move per strobe, saturating at both ends
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count_out <= {W{1'b0}};
    end else if (ce_in && tick_in && on_in && ss_in) begin
      if (up_in)
        count_out <= (sum_up > max_v) ? {W{1'b1}} : sum_up[W-1:0];
      else
        count_out <= sum_dn[W] ? {W{1'b0}} : sum_dn[W-1:0];
    end
  end
endmodule // sfcw_bias_ctr
`default_nettype wire

//--- sfcw_consts.vh
/*
 * constants for the servo focus/track control word block: register map,
 * field positions, reset values and timing.
 * assumes a 40 MHz core clock and an AXI4-Lite master with 32-bit data.
 */
// What this block does
// [R01] bias step 1,2,4,8 per cycle
// [R02] bias updates once per sampling cycle
// [R03] dac carries data word when selected
// [R04] surf jump freezes tracking filter output
// [R05] brake masks drive using sampled mirror
// [R06] mirror high masks tracking filter input; code masks only with brake and input-mask bits both set
// [R07] focus/track gain 0,6,12,18 dB
`ifndef SFCW_CONSTS_VH
`define SFCW_CONSTS_VH

// register byte addresses
`define SFCW_CTRL_ADDR      4'h0
`define SFCW_DWORD_ADDR     4'h4
`define SFCW_STAT_ADDR      4'h8
`define SFCW_ADDR_W         4

// control word fields
`define SFCW_BIAS_ON_BIT    14
`define SFCW_BIAS_SS_BIT    13
`define SFCW_BIAS_UP_BIT    12
`define SFCW_STEP_HI        11
`define SFCW_STEP_LO        10
`define SFCW_FZC_SRC_BIT    9
`define SFCW_JREL_BIT       8
`define SFCW_FGAIN_HI       7
`define SFCW_FGAIN_LO       6
`define SFCW_TGAIN_HI       5
`define SFCW_TGAIN_LO       4
`define SFCW_DAC_SRC_BIT    3
`define SFCW_SJ_HOLD_BIT    2
`define SFCW_BRAKE_BIT      1
`define SFCW_IN_MASK_BIT    0
`define SFCW_CTRL_W         15
`define SFCW_CTRL_RST       15'h0000
`define SFCW_DWORD_RST      16'h0000

// axi responses
`define SFCW_RESP_OKAY      2'b00
`define SFCW_RESP_SLVERR    2'b10

// focus servo sampling rate against the core clock
`define SFCW_CLK_HZ         40000000
`define SFCW_SAMPLE_HZ      88200
`define SFCW_SAMPLE_CYC     (`SFCW_CLK_HZ / `SFCW_SAMPLE_HZ)

`endif

//--- sfcw_mcu_model.sv
/* mcu model: axi4-lite master issuing single register cycles.
   assumes the bench bounds every wait for an answer. */
`timescale 1ns/1ps
`default_nettype none
module sfcw_mcu_model (
  input  wire logic        core_clk_in,
  output var  logic [31:0] s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [31:0] s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  // one write; payload inverted once released
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_in);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    s_axi_awaddr <= ~a;
    s_axi_wdata  <= ~d;
  endtask
  // one read
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_in);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    s_axi_araddr <= ~a;
  endtask
endmodule // sfcw_mcu_model
`default_nettype wire

//--- sfcw_monitor.sv
/* checker on the sfcw_top ports.
   assumes ce_in high and each write offered with address and data together. */
`timescale 1ns/1ps
`default_nettype none
module sfcw_monitor #(
  parameter DW     = 16,
  parameter BIAS_W = 10
) (
  input wire logic              core_clk_in,
  input wire logic              sys_rst_in,
  input wire logic [31:0]       s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic [DW-1:0]     focus_filt_in,
  input wire logic [DW-1:0]     track_err_in,
  input wire logic [DW-1:0]     audio_in,
  input wire logic              mirror_sig_in,
  input wire logic              track_zero_cross_in,
  input wire logic              brake_active_in,
  input wire logic [DW-1:0]     focus_drive_out,
  input wire logic [DW-1:0]     track_drive_out,
  input wire logic [DW-1:0]     track_filt_feed_out,
  input wire logic [DW-1:0]     dac_data_out,
  input wire logic [BIAS_W-1:0] focus_bias_counter_out,
  input wire logic              sample_tick_out
);
  reg  [14:0]       ctrl_reg;
  reg  [DW-1:0]     dword_reg, dac_reg;
  reg  [8:0]        gap_reg;
  reg  [BIAS_W-1:0] prev_reg;
  reg               zc_reg, canc_reg, live_reg, seen_reg;
  wire              take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire [BIAS_W-1:0] cnt  = focus_bias_counter_out;
  wire [BIAS_W-1:0] step = (cnt > prev_reg) ? cnt - prev_reg : prev_reg - cnt;
  wire              brk  = ~ctrl_reg[1] & brake_active_in & canc_reg;
  wire              msk  = ctrl_reg[1] & ctrl_reg[0] & mirror_sig_in;
  wire [1:0]        fgain = ctrl_reg[7:6];
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // shadow control word, cancel flag, dac source and tick spacing
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {ctrl_reg, dword_reg, dac_reg, gap_reg, prev_reg, zc_reg, canc_reg, live_reg, seen_reg} <= '0;
    end else begin
      if (take && s_axi_awaddr[3:0] == 4'h0) ctrl_reg <= s_axi_wdata[14:0];
      if (take && s_axi_awaddr[3:0] == 4'h4) dword_reg <= s_axi_wdata[DW-1:0];
      dac_reg  <= ctrl_reg[3] ? dword_reg : audio_in;
      zc_reg   <= track_zero_cross_in;
      if (zc_reg != track_zero_cross_in) canc_reg <= mirror_sig_in;
      gap_reg  <= sample_tick_out ? 9'h000 : gap_reg + 9'h001;
      prev_reg <= cnt;
      live_reg <= 1'b1;
      seen_reg <= seen_reg | sample_tick_out;
    end
  end
  chk_tick_spacing: assert property (sample_tick_out && seen_reg |-> gap_reg == 9'h1c4)
    else $error("tick spacing wrong");
  chk_bias_step: assert property (live_reg && cnt != prev_reg |-> (step inside {1, 2, 4, 8} || cnt == 0 || &cnt)
    && (sample_tick_out || $past(sample_tick_out) || $past(sample_tick_out, 2) || $past(sample_tick_out, 3)))
    else $error("bias counter moved wrongly");
  chk_dac_source: assert property (live_reg |-> dac_data_out == dac_reg)
    else $error("dac source wrong");
  chk_focus_gain: assert property (live_reg && $past(fgain) == 2'h0 |-> focus_drive_out == $past(focus_filt_in))
    else $error("unity focus gain wrong");
  chk_brake_mask: assert property (live_reg && $past(brk) |-> track_drive_out == '0)
    else $error("drive not masked");
  chk_feed_zero: assert property (live_reg && $past(msk) |-> track_filt_feed_out == '0)
    else $error("filter input not masked");
  chk_feed_pass: assert property (live_reg && !$past(mirror_sig_in) |-> track_filt_feed_out == $past(track_err_in))
    else $error("filter input altered");
  chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while response pending");
  chk_write_answer: assert property (take |=> s_axi_bvalid)
    else $error("write response late");
  cover property (sample_tick_out && seen_reg);
  cover property (live_reg && $past(brk));
  cover property (msk);
  cover property (ctrl_reg[3]);
endmodule // sfcw_monitor

bind sfcw_top sfcw_monitor #(.DW(DW), .BIAS_W(BIAS_W)) u_chk (.core_clk_in, .sys_rst_in, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .focus_filt_in,
  .track_err_in, .audio_in, .mirror_sig_in, .track_zero_cross_in, .brake_active_in, .focus_drive_out,
  .track_drive_out, .track_filt_feed_out, .dac_data_out, .focus_bias_counter_out, .sample_tick_out);
`default_nettype wire

//--- sfcw_tb.sv
/* testbench for sfcw_top driven through the mcu model.
   assumes a 40 MHz clock and servo inputs synchronous to it. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk_in, sys_rst_in, ce_in, mirror_sig_in, track_zero_cross_in, surf_jump_in, brake_active_in;
  logic [15:0] focus_filt_in, track_filt_in, track_err_in, audio_in;
  logic [31:0] rdat;
  logic [1:0]  rsp;
  logic [9:0]  c0, c1;
  wire  [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  wire  [15:0] focus_drive_out, track_drive_out, track_filt_feed_out, dac_data_out;
  wire  [9:0]  focus_bias_counter_out;
  wire  [3:0]  s_axi_wstrb;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sample_tick_out;
  wire         fzc_slice_src_sel_out, jump_release_ctl_out;
  int          n_fail = 0, n_tests = 0, cyc = 0;

  sfcw_top uut (.core_clk_in, .sys_rst_in, .ce_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .focus_filt_in,
    .track_filt_in, .track_err_in, .audio_in, .mirror_sig_in, .track_zero_cross_in, .surf_jump_in,
    .brake_active_in, .focus_drive_out, .track_drive_out, .track_filt_feed_out, .dac_data_out,
    .focus_bias_counter_out, .sample_tick_out, .fzc_slice_src_sel_out, .jump_release_ctl_out);
  sfcw_mcu_model mcu (.core_clk_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 40 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // hang guard
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up;
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task tk(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task w(input logic [31:0] a, input logic [31:0] d);
    mcu.wr(a, d, rsp);
    check(rsp, 32'h0000_0000);
  endtask
  task tick_cnt(output logic [9:0] v);
    do @(posedge core_clk_in); while (sample_tick_out !== 1'b1);
    tk(4);
    v = focus_bias_counter_out;
  endtask
  task t_regs;
    mcu.rd(32'h0000_0000, rdat, rsp);
    check(rdat, 32'h0000_0000);
    w(32'h0000_0008, 32'h0000_0008);
    mcu.rd(32'h0000_0000, rdat, rsp);
    check(rdat, 32'h0000_0000);
    mcu.rd(32'h0000_000c, rdat, rsp);
    check({rdat[29:0], rsp}, 32'h0000_0002);
    // pass-through control bits reach their pins and read back
    w(32'h0000_0000, 32'h0000_0300);
    tk(2);
    check({fzc_slice_src_sel_out, jump_release_ctl_out}, 32'h0000_0003);
    mcu.rd(32'h0000_0000, rdat, rsp);
    check(rdat, 32'h0000_0300);
    $display("t_regs done");
  endtask
  task t_dac;
    w(32'h0000_0004, 32'h0000_1234);
    w(32'h0000_0000, 32'h0000_0008);
    tk(2);
    check(dac_data_out, 32'h0000_1234);
    w(32'h0000_0000, 32'h0000_0000);
    tk(2);
    check(dac_data_out, 32'h0000_5a5a);
    $display("t_dac done");
  endtask
  task t_gain;
    focus_filt_in <= 16'h0010;
    track_filt_in <= 16'h0010;
    for (int k = 0; k < 4; k++) begin
      w(32'h0000_0000, (k << 6) | (k << 4));
      tk(2);
      check(focus_drive_out, 32'h0000_0010 << k);
      check(track_drive_out, 32'h0000_0010 << k);
    end
    focus_filt_in <= 16'h2000;
    tk(2);
    check(focus_drive_out, 32'h0000_7fff);
    w(32'h0000_0000, 32'h0000_0000);
    $display("t_gain done");
  endtask
  task t_brake;
    track_filt_in <= 16'h0040;
    mirror_sig_in <= 1'b1;
    tk(1);
    track_zero_cross_in <= 1'b1;
    brake_active_in <= 1'b1;
    tk(3);
    check(track_drive_out, 32'h0000_0000);
    mirror_sig_in <= 1'b0;
    tk(1);
    track_zero_cross_in <= 1'b0;
    tk(3);
    check(track_drive_out, 32'h0000_0040);
    brake_active_in <= 1'b0;
    track_err_in <= 16'h0077;
    w(32'h0000_0000, 32'h0000_0001);
    mirror_sig_in <= 1'b1;
    tk(2);
    check(track_filt_feed_out, 32'h0000_0077);
    w(32'h0000_0000, 32'h0000_0003);
    tk(2);
    check(track_filt_feed_out, 32'h0000_0000);
    mirror_sig_in <= 1'b0;
    tk(2);
    check(track_filt_feed_out, 32'h0000_0077);
    $display("t_brake done");
  endtask
  task t_hold;
    track_filt_in <= 16'h0100;
    w(32'h0000_0000, 32'h0000_0004);
    surf_jump_in <= 1'b1;
    tk(3);
    track_filt_in <= 16'h0200;
    tk(2);
    check(track_drive_out, 32'h0000_0100);
    surf_jump_in <= 1'b0;
    tk(2);
    check(track_drive_out, 32'h0000_0200);
    // hold bit clear: drive keeps following the filter during a jump
    w(32'h0000_0000, 32'h0000_0000);
    surf_jump_in <= 1'b1;
    tk(3);
    track_filt_in <= 16'h0300;
    tk(2);
    check(track_drive_out, 32'h0000_0300);
    surf_jump_in <= 1'b0;
    $display("t_hold done");
  endtask
  task t_bias;
    for (int k = 0; k < 4; k++) begin
      w(32'h0000_0000, 32'h0000_7000 | (k << 10));
      tick_cnt(c0);
      tick_cnt(c1);
      check(c1 - c0, 32'h0000_0001 << k);
    end
    w(32'h0000_0000, 32'h0000_3000);
    tick_cnt(c0);
    tick_cnt(c1);
    check(c1 - c0, 32'h0000_0000);
    // status word carries the resting count, cancel and hold clear
    mcu.rd(32'h0000_0008, rdat, rsp);
    check(rdat, {22'h00_0000, c1});
    // count down by eight per sampling cycle
    w(32'h0000_0000, 32'h0000_6c00);
    tick_cnt(c0);
    tick_cnt(c1);
    check(c0 - c1, 32'h0000_0008);
    $display("t_bias done");
  endtask
  // reset, then each scenario in turn
  initial begin
    {sys_rst_in, ce_in} = 2'h3;
    {mirror_sig_in, track_zero_cross_in, surf_jump_in, brake_active_in} = 4'h0;
    {focus_filt_in, track_filt_in, track_err_in} = '0;
    audio_in = 16'h5a5a;
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    t_regs;
    t_dac;
    t_gain;
    t_brake;
    t_hold;
    t_bias;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire

//--- sfcw_top.v
/*
 * servo focus/track control word: axi4-lite register slave, focus bias
 * stepping, drive gain, dac source select, surf jump hold and brake masks.
 * assumes all servo inputs are synchronous to core_clk_in and that the
 * brake and surf jump levels come from the servo sequencer.
 */
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sfcw_consts.vh"
module sfcw_top #(
  parameter DW     = 16,
  parameter BIAS_W = 10
) (
  input  wire              core_clk_in,
  input  wire              sys_rst_in,
  input  wire              ce_in,
  // axi4-lite slave
  input  wire [31:0]       s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [31:0]       s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // servo datapath
  input  wire [DW-1:0]     focus_filt_in,
  input  wire [DW-1:0]     track_filt_in,
  input  wire [DW-1:0]     track_err_in,
  input  wire [DW-1:0]     audio_in,
  input  wire              mirror_sig_in,
  input  wire              track_zero_cross_in,
  input  wire              surf_jump_in,
  input  wire              brake_active_in,
  output reg  [DW-1:0]     focus_drive_out,
  output reg  [DW-1:0]     track_drive_out,
  output reg  [DW-1:0]     track_filt_feed_out,
  output reg  [DW-1:0]     dac_data_out,
  output reg  [BIAS_W-1:0] focus_bias_counter_out,
  output reg               sample_tick_out,
  output reg               fzc_slice_src_sel_out,
  output reg               jump_release_ctl_out
);
  // divider end point, cut to the divider width on purpose
  localparam integer SAMPLE_CYC  = `SFCW_SAMPLE_CYC;
  localparam [8:0]   SAMPLE_LAST = SAMPLE_CYC[8:0] - 9'h001;

  // signed left shift by 0..3 with saturation
  function [DW-1:0] sat_gain;
    input [DW-1:0] x;
    input [1:0]    sh;
    reg   [DW+2:0] ext;
    reg   [DW+2:0] shf;
    begin
      ext = {{3{x[DW-1]}}, x};
      shf = ext << sh;
      if (shf[DW+2:DW-1] == {4{1'b0}} || shf[DW+2:DW-1] == {4{1'b1}})
        sat_gain = shf[DW-1:0];
      else if (shf[DW+2])
        sat_gain = {1'b1, {(DW-1){1'b0}}};
      else
        sat_gain = {1'b0, {(DW-1){1'b1}}};
    end
  endfunction

  reg  [`SFCW_CTRL_W-1:0] ctrl_reg;
  reg  [DW-1:0]           dword_reg;
  reg  [8:0]              div_reg;
  reg                     tick_reg;
  reg                     aw_got_reg;
  reg                     w_got_reg;
  reg  [`SFCW_ADDR_W-1:0] awaddr_reg;
  reg  [31:0]             wdata_reg;
  reg  [3:0]              wstrb_reg;
  reg                     tzc_prev_reg;
  reg                     track_cancel_sig_reg;
  reg                     sj_prev_reg;
  reg  [DW-1:0]           sj_hold_val_reg;
  reg  [31:0]             rdata_next;
  reg  [1:0]              rresp_next;
  wire [BIAS_W-1:0]       bias_count;
  wire                    aw_have;
  wire                    w_have;
  wire [`SFCW_ADDR_W-1:0] wr_addr;
  wire [31:0]             wr_data;
  wire [3:0]              wr_strb;
  wire                    sj_hold_now;
  wire                    cancel_mask;
  wire                    input_mask;
  wire [DW-1:0]           track_gained;

  // [R02] sampling cycle strobe
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_reg  <= 9'h000;
      tick_reg <= 1'b0;
    end else if (ce_in) begin
      tick_reg <= (div_reg == SAMPLE_LAST);
      div_reg  <= (div_reg == SAMPLE_LAST) ? 9'h000 : div_reg + 9'h001;
    end
  end

  // [R01] bias counter stepping
  sfcw_bias_ctr #(
    .W (BIAS_W)
  ) u_bias (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .ce_in       (ce_in),
    .tick_in     (tick_reg),
    .on_in       (ctrl_reg[`SFCW_BIAS_ON_BIT]),
    .ss_in       (ctrl_reg[`SFCW_BIAS_SS_BIT]),
    .up_in       (ctrl_reg[`SFCW_BIAS_UP_BIT]),
    .step_sel_in (ctrl_reg[`SFCW_STEP_HI:`SFCW_STEP_LO]),
    .count_out   (bias_count)
  );

  // write channel: address and data taken in either order
  assign aw_have = aw_got_reg | (s_axi_awvalid & s_axi_awready);
  assign w_have  = w_got_reg | (s_axi_wvalid & s_axi_wready);
  assign wr_addr = aw_got_reg ? awaddr_reg : s_axi_awaddr[`SFCW_ADDR_W-1:0];
  assign wr_data = w_got_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_got_reg ? wstrb_reg : s_axi_wstrb;

  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SFCW_RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= {`SFCW_ADDR_W{1'b0}};
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      ctrl_reg      <= `SFCW_CTRL_RST;
      dword_reg     <= `SFCW_DWORD_RST;
    end else if (ce_in) begin
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready  <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr[`SFCW_ADDR_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        aw_got_reg    <= 1'b0;
        w_got_reg     <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= `SFCW_RESP_OKAY;
        // byte lanes: low two lanes hold the 16-bit words
        case (wr_addr)
          `SFCW_CTRL_ADDR: begin
            if (wr_strb[0])
              ctrl_reg[7:0] <= wr_data[7:0];
            if (wr_strb[1])
              ctrl_reg[`SFCW_CTRL_W-1:8] <= wr_data[`SFCW_CTRL_W-1:8];
          end
          `SFCW_DWORD_ADDR: begin
            if (wr_strb[0])
              dword_reg[7:0] <= wr_data[7:0];
            if (wr_strb[1])
              dword_reg[DW-1:8] <= wr_data[DW-1:8];
          end
          `SFCW_STAT_ADDR: begin
            s_axi_bresp <= `SFCW_RESP_OKAY; // read-only, write ignored
          end
          default: begin
            s_axi_bresp <= `SFCW_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  always @* begin
    rdata_next = 32'h0000_0000;
    rresp_next = `SFCW_RESP_OKAY;
    case (s_axi_araddr[`SFCW_ADDR_W-1:0])
      `SFCW_CTRL_ADDR:  rdata_next[`SFCW_CTRL_W-1:0] = ctrl_reg;
      `SFCW_DWORD_ADDR: rdata_next[DW-1:0] = dword_reg;
      `SFCW_STAT_ADDR:  rdata_next = {14'h0000, sj_hold_now, track_cancel_sig_reg,
                                      {(16-BIAS_W){1'b0}}, bias_count};
      default:          rresp_next = `SFCW_RESP_SLVERR;
    endcase
  end

  // read channel: answer one cycle after address taken
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SFCW_RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_next;
        s_axi_rresp   <= rresp_next;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end else begin
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end

  // [R04] hold active while jumping with hold bit set
  assign sj_hold_now  = surf_jump_in & sj_prev_reg & ctrl_reg[`SFCW_SJ_HOLD_BIT];
  // [R05] cancel masks drive during braking
  assign cancel_mask  = ~ctrl_reg[`SFCW_BRAKE_BIT] & brake_active_in & track_cancel_sig_reg;
  // [R06] mirror high masks filter input when brake and input-mask bits are both set
  assign input_mask   = ctrl_reg[`SFCW_BRAKE_BIT] & ctrl_reg[`SFCW_IN_MASK_BIT] & mirror_sig_in;
  // [R07] tracking gain into drive stage
  assign track_gained = sat_gain(track_filt_in, ctrl_reg[`SFCW_TGAIN_HI:`SFCW_TGAIN_LO]);

  // mirror capture and surf jump tracking
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tzc_prev_reg         <= 1'b0;
      track_cancel_sig_reg <= 1'b0;
      sj_prev_reg          <= 1'b0;
      sj_hold_val_reg      <= {DW{1'b0}};
    end else if (ce_in) begin
      tzc_prev_reg <= track_zero_cross_in;
      sj_prev_reg  <= surf_jump_in;
      // [R05] sample mirror on zero-cross edge
      if (track_zero_cross_in != tzc_prev_reg)
        track_cancel_sig_reg <= mirror_sig_in;
      // [R04] capture value at jump start
      if (surf_jump_in && !sj_prev_reg)
        sj_hold_val_reg <= track_gained;
    end
  end

  // output stage
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      focus_drive_out        <= {DW{1'b0}};
      track_drive_out        <= {DW{1'b0}};
      track_filt_feed_out    <= {DW{1'b0}};
      dac_data_out           <= {DW{1'b0}};
      focus_bias_counter_out <= {BIAS_W{1'b0}};
      sample_tick_out        <= 1'b0;
      fzc_slice_src_sel_out  <= 1'b0;
      jump_release_ctl_out   <= 1'b0;
    end else if (ce_in) begin
      // [R07] focus gain into drive stage
      focus_drive_out <= sat_gain(focus_filt_in, ctrl_reg[`SFCW_FGAIN_HI:`SFCW_FGAIN_LO]);
      // [R04] [R05] held or masked tracking drive
      if (cancel_mask)
        track_drive_out <= {DW{1'b0}};
      else if (sj_hold_now)
        track_drive_out <= sj_hold_val_reg;
      else
        track_drive_out <= track_gained;
      // [R06] masked filter input
      track_filt_feed_out <= input_mask ? {DW{1'b0}} : track_err_in;
      // [R03] dac source select
      dac_data_out <= ctrl_reg[`SFCW_DAC_SRC_BIT] ? dword_reg : audio_in;
      focus_bias_counter_out <= bias_count;
      sample_tick_out        <= tick_reg;
      fzc_slice_src_sel_out  <= ctrl_reg[`SFCW_FZC_SRC_BIT];
      jump_release_ctl_out   <= ctrl_reg[`SFCW_JREL_BIT];
    end
  end
endmodule // sfcw_top
`default_nettype wire
